// ===== src/rcr_core.v
// Purpose: register file, flags, program counter and return stack of an 8-bit core
// Assumes: program memory answers in the same cycle; requests come from other clocks
// Notes: one instruction per clock; data memory stores are posted one cycle late
// How it works
// - sixteen eight-bit registers in one array
// - register pairs read as one 16-bit word
// - decoder takes 22-bit instruction words
// - each instruction finishes in one clock
// - halt ends on interrupt or event request
// - interrupt wake branches, event wake continues
// - 16-bit program counter points at next instruction
// - hardware stack keeps return addresses
// - one data index from a high/low pair
// - program index pair plus data offset register
// - status bits 7,6 enable levels 2,1
// - status bit 5 gates all interrupt levels
// - status bits 4..2 record interrupt requests
// - interrupt request bits stay until software clears
// - status bits 1,0 hold event requests
// - zero flag tracks accumulator equal zero
// - shift carry is the bit shifted out
// - add carry on overflow, subtract clears on underflow
// - overflow flag marks signed over/underflow
// - call pushes return address, loads target
// - interrupt return pops and sets global enable
`include "rcr_defs.vh"
module rcr_core #(
  parameter STACK_DEPTH = 8
) (
  // clock and reset
  input wire clk_sys_i,
  input wire arst_n_i,
  // program memory
  input wire [21:0] instr_i,
  output reg [15:0] pc_o,
  // data memory
  input wire [7:0] dm_rdata_i,
  output reg [15:0] dm_addr_o,
  output reg [7:0] dm_wdata_o,
  output reg dm_we_o,
  // request sources, asynchronous levels
  input wire [2:0] irq_src_i,
  input wire [1:0] evt_src_i,
  // observed state
  output reg [7:0] acc_o,
  output reg [7:0] stat_o,
  output reg [2:0] flags_o,
  output reg halted_o
);
  reg [7:0] regs_ff [0:15];
  reg [15:0] stack_ff [0:STACK_DEPTH-1];
  reg [15:0] pc_ff;
  reg z_ff, c_ff, v_ff, halted_ff;
  reg [4:0] req_s1_ff, req_s2_ff, req_s3_ff;
  integer k;

  // two registers viewed as one wide operand
  function [15:0] pair;
    input [7:0] hi;
    input [7:0] lo;
    begin
      pair = {hi, lo};
    end
  endfunction

  wire [5:0] op = instr_i[21:16];
  wire [3:0] rd = instr_i[15:12];
  wire [3:0] rs = instr_i[11:8];
  wire [7:0] imm = instr_i[7:0];
  wire [15:0] tgt = instr_i[15:0];
  wire [7:0] vd = regs_ff[rd];
  wire [7:0] vs = regs_ff[rs];
  wire [7:0] st = regs_ff[`RCR_STAT];
  wire [15:0] ip = pair(regs_ff[`RCR_IPH], regs_ff[`RCR_IPL]);
  wire [15:0] pc_inc = pc_ff + 16'h0001;

  // a request counts once the second and third stages agree
  wire [4:0] req_set = req_s2_ff & req_s3_ff;

  // level 0 has no level enable of its own
  wire irq_take = st[`RCR_ST_GIE] & ((st[`RCR_ST_IN2] & st[`RCR_ST_IE2]) |
    (st[`RCR_ST_IN1] & st[`RCR_ST_IE1]) | st[`RCR_ST_IN0]);
  wire evt_any = st[`RCR_ST_EV1] | st[`RCR_ST_EV0];

  // execute stage, all combinational so every op ends in this clock
  reg [15:0] nxt_pc;
  reg [7:0] nxt_acc, wr_data;
  reg acc_we, wr_en, nxt_c, nxt_v, push, pop, ip_we, gie_set, gie_clr;
  reg nxt_halted, st_we, nxt_dm_we;
  reg [15:0] push_val, ip_val;
  reg [8:0] sum;
  reg [15:0] prod;
  always @* begin
    nxt_pc = pc_inc;
    nxt_acc = regs_ff[`RCR_ACC];
    acc_we = 1'b0;
    wr_en = 1'b0;
    wr_data = vs;
    nxt_c = c_ff;
    nxt_v = v_ff;
    push = 1'b0;
    pop = 1'b0;
    push_val = pc_inc;
    ip_we = 1'b0;
    ip_val = pc_inc;
    gie_set = 1'b0;
    gie_clr = 1'b0;
    nxt_halted = halted_ff;
    nxt_dm_we = 1'b0;
    sum = 9'h000;
    prod = vd * vs;
    if (irq_take) begin
      // interrupt entry replaces the fetched instruction
      nxt_pc = `RCR_IRQ_VEC;
      push = 1'b1;
      push_val = pc_ff;
      gie_clr = 1'b1;
      nxt_halted = 1'b0;
    end else if (halted_ff) begin
      // pc already points past the halt, so an event just resumes
      nxt_pc = pc_ff;
      if (evt_any) begin
        nxt_halted = 1'b0;
      end
    end else begin
      case (op)
        `RCR_OP_JMP: nxt_pc = tgt;
        `RCR_OP_JIP: nxt_pc = ip;
        `RCR_OP_JZ: if (z_ff) nxt_pc = tgt;
        `RCR_OP_JNZ: if (!z_ff) nxt_pc = tgt;
        `RCR_OP_JC: if (c_ff) nxt_pc = tgt;
        `RCR_OP_JNC: if (!c_ff) nxt_pc = tgt;
        `RCR_OP_JV: if (v_ff) nxt_pc = tgt;
        `RCR_OP_CALL: begin
          push = 1'b1;
          nxt_pc = tgt;
        end
        `RCR_OP_RET: begin
          pop = 1'b1;
          nxt_pc = stack_ff[0];
        end
        `RCR_OP_RETI: begin
          pop = 1'b1;
          nxt_pc = stack_ff[0];
          gie_set = 1'b1;
        end
        `RCR_OP_PUSH: begin
          push = 1'b1;
          push_val = ip;
        end
        `RCR_OP_POP: begin
          pop = 1'b1;
          ip_we = 1'b1;
          ip_val = stack_ff[0];
        end
        `RCR_OP_MOVI: begin
          wr_en = 1'b1;
          wr_data = imm;
        end
        `RCR_OP_MOVR: wr_en = 1'b1;
        `RCR_OP_LOAD: begin
          wr_en = 1'b1;
          wr_data = dm_rdata_i;
        end
        `RCR_OP_STORE: nxt_dm_we = 1'b1;
        `RCR_OP_SHL, `RCR_OP_SHLC: begin
          wr_en = 1'b1;
          wr_data = {vs[6:0], (op == `RCR_OP_SHLC) & c_ff};
          nxt_c = vs[7];
          nxt_v = vs[7] ^ vs[6];
        end
        `RCR_OP_SHR, `RCR_OP_SHRC, `RCR_OP_SHRA: begin
          wr_en = 1'b1;
          wr_data = {(op == `RCR_OP_SHRC) ? c_ff : (op == `RCR_OP_SHRA) & vs[7], vs[7:1]};
          nxt_c = vs[0];
          nxt_v = 1'b0;
        end
        `RCR_OP_ADD, `RCR_OP_ADDC: begin
          sum = {1'b0, vd} + {1'b0, vs} + {8'h00, (op == `RCR_OP_ADDC) & c_ff};
          wr_en = 1'b1;
          wr_data = sum[7:0];
          nxt_c = sum[8];
          nxt_v = (vd[7] == vs[7]) & (sum[7] != vd[7]);
        end
        `RCR_OP_SUB, `RCR_OP_SUBC: begin
          // carry acts as not-borrow: cleared on underflow
          sum = {1'b0, vd} - {1'b0, vs} - {8'h00, (op == `RCR_OP_SUBC) & ~c_ff};
          wr_en = 1'b1;
          wr_data = sum[7:0];
          nxt_c = ~sum[8];
          nxt_v = (vd[7] != vs[7]) & (sum[7] != vd[7]);
        end
        `RCR_OP_MUL: begin
          // low byte to the register, high byte stays in the accumulator
          wr_en = 1'b1;
          wr_data = prod[7:0];
        end
        `RCR_OP_AND: begin
          wr_en = 1'b1;
          wr_data = vd & vs;
        end
        `RCR_OP_OR: begin
          wr_en = 1'b1;
          wr_data = vd | vs;
        end
        `RCR_OP_XOR: begin
          wr_en = 1'b1;
          wr_data = vd ^ vs;
        end
        `RCR_OP_CMVD: wr_en = ~c_ff;
        `RCR_OP_CMVS: wr_en = c_ff;
        `RCR_OP_HALT: nxt_halted = 1'b1;
        default: nxt_pc = pc_inc;
      endcase
      // every data op except store also leaves its result in the accumulator
      if (op >= `RCR_OP_MOVI && op <= `RCR_OP_CMVS && op != `RCR_OP_STORE) begin
        acc_we = 1'b1;
        nxt_acc = (op == `RCR_OP_MUL) ? prod[15:8] : wr_data;
      end
    end
    st_we = wr_en & (rd == `RCR_STAT);
  end

  // accumulator as it stands after this clock, for the zero flag
  wire [7:0] acc_after = (wr_en && rd == `RCR_ACC) ? wr_data : nxt_acc;

  // status byte: a hardware set wins over a software clear in the same clock
  wire [7:0] st_base = st_we ? wr_data : st;
  wire [7:0] st_gie = (st_base & ~{2'b00, gie_clr, 5'h00}) | {2'b00, gie_set, 5'h00};
  wire [7:0] nxt_stat = st_gie | {3'b000, req_set};

  // request synchronisers, three stages per source
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      req_s1_ff <= 5'h00;
      req_s2_ff <= 5'h00;
      req_s3_ff <= 5'h00;
    end else begin
      req_s1_ff <= {irq_src_i, evt_src_i};
      req_s2_ff <= req_s1_ff;
      req_s3_ff <= req_s2_ff;
    end
  end

  // architectural state update
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (k = 0; k < 16; k = k + 1) begin
        regs_ff[k] <= 8'h00;
      end
      for (k = 0; k < STACK_DEPTH; k = k + 1) begin
        stack_ff[k] <= 16'h0000;
      end
      pc_ff <= 16'h0000;
      z_ff <= 1'b1;
      c_ff <= 1'b0;
      v_ff <= 1'b0;
      halted_ff <= 1'b0;
    end else begin
      pc_ff <= nxt_pc;
      c_ff <= nxt_c;
      v_ff <= nxt_v;
      z_ff <= (acc_after == 8'h00);
      halted_ff <= nxt_halted;
      if (acc_we) begin
        regs_ff[`RCR_ACC] <= nxt_acc;
      end
      // the named destination wins over the accumulator copy
      if (wr_en && rd != `RCR_STAT) begin
        regs_ff[rd] <= wr_data;
      end
      if (ip_we) begin
        regs_ff[`RCR_IPH] <= ip_val[15:8];
        regs_ff[`RCR_IPL] <= ip_val[7:0];
      end
      regs_ff[`RCR_STAT] <= nxt_stat;
      // newest entry on top, oldest falls off the bottom when full
      if (push) begin
        stack_ff[0] <= push_val;
        for (k = 1; k < STACK_DEPTH; k = k + 1) begin
          stack_ff[k] <= stack_ff[k-1];
        end
      end else if (pop) begin
        for (k = 0; k < STACK_DEPTH - 1; k = k + 1) begin
          stack_ff[k] <= stack_ff[k+1];
        end
      end
    end
  end

  // registered outputs; loads use index 0 plus the data offset
  always @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pc_o <= 16'h0000;
      dm_addr_o <= 16'h0000;
      dm_wdata_o <= 8'h00;
      dm_we_o <= 1'b0;
      acc_o <= 8'h00;
      stat_o <= `RCR_STAT_RST;
      flags_o <= 3'b001;
      halted_o <= 1'b0;
    end else begin
      pc_o <= nxt_pc;
      dm_addr_o <= pair(regs_ff[`RCR_I0H], regs_ff[`RCR_I0L]) + {8'h00, regs_ff[`RCR_R3]};
      dm_wdata_o <= vd;
      dm_we_o <= nxt_dm_we;
      // a multiply into the accumulator keeps the low byte, so mirror what lands
      acc_o <= acc_after;
      stat_o <= nxt_stat;
      flags_o <= {nxt_v, nxt_c, acc_after == 8'h00};
      halted_o <= nxt_halted;
    end
  end
endmodule // rcr_core

// ===== include/rcr_defs.vh
// Purpose: constants for the core register file, status bits and opcodes
// Assumes: included once per design file
// Notes: opcode values are local to this core's decoder
`ifndef RCR_DEFS_VH
`define RCR_DEFS_VH
// register file indexes
`define RCR_R0 4'h0
`define RCR_R3 4'h3
`define RCR_I0H 4'h4
`define RCR_I0L 4'h5
`define RCR_IPH 4'hc
`define RCR_IPL 4'hd
`define RCR_STAT 4'he
`define RCR_ACC 4'hf
// status register fields and reset
`define RCR_ST_IE2 7
`define RCR_ST_IE1 6
`define RCR_ST_GIE 5
`define RCR_ST_IN2 4
`define RCR_ST_IN1 3
`define RCR_ST_IN0 2
`define RCR_ST_EV1 1
`define RCR_ST_EV0 0
`define RCR_STAT_RST 8'h00
`define RCR_IRQ_VEC 16'h0001
// opcodes, instr[21:16]
`define RCR_OP_NOP 6'h00
`define RCR_OP_JMP 6'h01
`define RCR_OP_JIP 6'h02
`define RCR_OP_JZ 6'h03
`define RCR_OP_JNZ 6'h04
`define RCR_OP_JC 6'h05
`define RCR_OP_JNC 6'h06
`define RCR_OP_JV 6'h07
`define RCR_OP_CALL 6'h08
`define RCR_OP_RET 6'h09
`define RCR_OP_RETI 6'h0a
`define RCR_OP_PUSH 6'h0b
`define RCR_OP_POP 6'h0c
`define RCR_OP_MOVI 6'h0d
`define RCR_OP_MOVR 6'h0e
`define RCR_OP_LOAD 6'h0f
`define RCR_OP_STORE 6'h10
`define RCR_OP_SHL 6'h11
`define RCR_OP_SHLC 6'h12
`define RCR_OP_SHR 6'h13
`define RCR_OP_SHRC 6'h14
`define RCR_OP_SHRA 6'h15
`define RCR_OP_ADD 6'h16
`define RCR_OP_ADDC 6'h17
`define RCR_OP_SUB 6'h18
`define RCR_OP_SUBC 6'h19
`define RCR_OP_MUL 6'h1a
`define RCR_OP_AND 6'h1b
`define RCR_OP_OR 6'h1c
`define RCR_OP_XOR 6'h1d
`define RCR_OP_CMVD 6'h1e
`define RCR_OP_CMVS 6'h1f
`define RCR_OP_HALT 6'h20
`endif

// ===== bench/rcr_core_monitor.sv
// Purpose: port-level checks for the core registers, flags and stack
// Assumes: one clock domain, sees core ports only
// Notes: data values are judged by the bench
`include "rcr_defs.vh"
module rcr_core_monitor #(
  parameter STACK_DEPTH = 8
) (
  // clock and reset
  input wire clk_sys_i,
  input wire arst_n_i,
  // fetch and sources
  input wire [21:0] instr_i,
  input wire [2:0] irq_src_i,
  input wire [1:0] evt_src_i,
  // observed state
  input wire [15:0] pc_o,
  input wire [7:0] acc_o,
  input wire [7:0] stat_o,
  input wire [2:0] flags_o,
  input wire halted_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // an interrupt entry cycle executes no fetched word
  wire take = stat_o[5] && ((stat_o[4] && stat_o[7]) || (stat_o[3] && stat_o[6]) || stat_o[2]);
  wire go = !halted_o && !take;
  wire [5:0] op = instr_i[21:16];
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_call_reti;
    go && op == `RCR_OP_CALL ##1 go && op == `RCR_OP_RETI;
  endsequence
  a_zero_tracks_acc: assert property (flags_o[0] == (acc_o == 8'h00))
    else $error("zero flag wrong");
  a_call_target: assert property (go && op == `RCR_OP_CALL |=> pc_o == $past(instr_i[15:0]))
    else $error("call target wrong");
  a_call_return: assert property (s_call_reti |=> pc_o == $past(pc_o, 2) + 16'h0001)
    else $error("return address wrong");
  a_reti_sets_gie: assert property (go && op == `RCR_OP_RETI |=> stat_o[5])
    else $error("global enable not restored");
  a_irq_entry: assert property (take |=> pc_o == `RCR_IRQ_VEC && !stat_o[5])
    else $error("interrupt entry wrong");
  a_irq_req_sticky: assert property (stat_o[4] && instr_i[15:12] != `RCR_STAT |=> stat_o[4])
    else $error("request bit lost");
  a_irq_req_sets: assert property (irq_src_i[2] [*4] |=> stat_o[4])
    else $error("request bit not set");
  a_evt_req_sets: assert property (evt_src_i[0] [*4] |=> stat_o[0])
    else $error("event bit not set");
  a_halt_enter: assert property (go && op == `RCR_OP_HALT |=> halted_o && pc_o == $past(pc_o) + 16'h0001)
    else $error("halt entry wrong");
  a_halt_pc_hold: assert property (halted_o && $past(halted_o) |-> pc_o == $past(pc_o))
    else $error("pc moved while halted");
  a_event_wake: assert property (halted_o && !take && (stat_o[1] || stat_o[0]) |=> !halted_o && pc_o == $past(pc_o))
    else $error("event wake wrong");
endmodule // rcr_core_monitor

// ===== bench/rcr_mem_model.sv
// Purpose: program and data memory on the far side of the core
// Assumes: program word answers in the same cycle as its address
// Notes: 256 words each; upper address bits ignored
module rcr_mem_model (
  // clock
  input wire clk_sys_i,
  // program memory
  input wire [15:0] pc_i,
  output wire [21:0] instr_o,
  // data memory
  input wire [15:0] dm_addr_i,
  input wire [7:0] dm_wdata_i,
  input wire dm_we_i,
  output wire [7:0] dm_rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [21:0] rom [0:255];
  logic [7:0] ram [0:255];
  // blank program space reads as no-operation so stray fetches are harmless
  initial begin
    for (int i = 0; i < 256; i++) begin
      rom[i] = 22'h000000;
      ram[i] = 8'h00;
    end
  end
  assign instr_o = rom[pc_i[7:0]];
  assign dm_rdata_o = ram[dm_addr_i[7:0]];
  // posted stores land at the strobe edge
  always @(posedge clk_sys_i) begin
    if (dm_we_i) begin
      ram[dm_addr_i[7:0]] <= dm_wdata_i;
    end
  end
endmodule // rcr_mem_model

// ===== bench/tb.sv
// Purpose: self-checking bench for core registers, flags and stack
// Assumes: program loaded while reset is held
// Notes: request sources are driven directly as handler outputs
`include "rcr_defs.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STACK_DEPTH = 8;
  logic clk_sys_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [2:0] irq_src_i = 3'h0;
  logic [1:0] evt_src_i = 2'h0;
  wire [21:0] instr_i;
  wire [15:0] pc_o;
  wire [15:0] dm_addr_o;
  wire [7:0] dm_rdata_i;
  wire [7:0] dm_wdata_o;
  wire dm_we_o;
  wire [7:0] acc_o;
  wire [7:0] stat_o;
  wire [2:0] flags_o;
  wire halted_o;
  int err_total = 0;
  int n_compared = 0;
  logic [2:0] lv [2] = '{3'h4, 3'h1};
  rcr_core #(.STACK_DEPTH(STACK_DEPTH)) u_rcr_core (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .instr_i(instr_i), .pc_o(pc_o),
    .dm_rdata_i(dm_rdata_i), .dm_addr_o(dm_addr_o), .dm_wdata_o(dm_wdata_o),
    .dm_we_o(dm_we_o), .irq_src_i(irq_src_i), .evt_src_i(evt_src_i), .acc_o(acc_o),
    .stat_o(stat_o), .flags_o(flags_o), .halted_o(halted_o));
  rcr_mem_model u_rcr_mem_model (
    .clk_sys_i(clk_sys_i), .pc_i(pc_o), .instr_o(instr_i), .dm_addr_i(dm_addr_o),
    .dm_wdata_i(dm_wdata_o), .dm_we_i(dm_we_o), .dm_rdata_o(dm_rdata_i));
  // 200 MHz system clock
  always #2.5 clk_sys_i = ~clk_sys_i;
  // one program word: opcode on top, register and immediate fields below
  task automatic load(input logic [7:0] a, input logic [5:0] op, input logic [15:0] f);
    u_rcr_mem_model.rom[a] = {op, f};
  endtask
  // bounded wait for a fetch address; a miss shows as a mismatch
  task automatic wait_pc(input logic [15:0] p);
    for (int i = 0; i < 60 && pc_o !== p; i++) @(negedge clk_sys_i);
    `CHK(pc_o, p)
  endtask
  task automatic summarize;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // the program needs about a hundred cycles, so this only trips on a hang
  initial begin
    #20000;
    err_total++;
    summarize();
  end
  // main sequence; the service routine sits at the vector, padded with no-ops
  initial begin
    repeat (20) @(posedge clk_sys_i);
    load(8'h00, `RCR_OP_JMP, 16'h0010);
    load(8'h06, `RCR_OP_MOVI, 16'he080);
    load(8'h07, `RCR_OP_RETI, 16'h0000);
    load(8'h10, `RCR_OP_MOVI, 16'h0081);
    load(8'h11, `RCR_OP_SHL, 16'h0000);
    load(8'h12, `RCR_OP_SHR, 16'h0000);
    load(8'h13, `RCR_OP_SHR, 16'h0000);
    load(8'h14, `RCR_OP_MOVI, 16'h10ff);
    load(8'h15, `RCR_OP_MOVI, 16'h0001);
    load(8'h16, `RCR_OP_ADD, 16'h0100);
    load(8'h17, `RCR_OP_SUB, 16'h0100);
    load(8'h18, `RCR_OP_CALL, 16'h0030);
    load(8'h19, `RCR_OP_MOVI, 16'he0a0);
    load(8'h1a, `RCR_OP_HALT, 16'h0000);
    load(8'h1b, `RCR_OP_JMP, 16'h001b);
    load(8'h30, `RCR_OP_RETI, 16'h0000);
    // data path block, reached later by re-pointing the idle loop
    load(8'h40, `RCR_OP_MOVI, 16'h3005);
    load(8'h41, `RCR_OP_MOVI, 16'h5010);
    load(8'h42, `RCR_OP_MOVI, 16'h205a);
    load(8'h43, `RCR_OP_STORE, 16'h2000);
    load(8'h45, `RCR_OP_LOAD, 16'h1000);
    load(8'h46, `RCR_OP_MUL, 16'h1200);
    load(8'h47, `RCR_OP_JMP, 16'h0047);
    `CHK(pc_o, 16'h0000)
    `CHK(stat_o, `RCR_STAT_RST)
    `CHK(flags_o, 3'b001)
    arst_n_i <= 1'b1;
    wait_pc(16'h0012);
    `CHK(acc_o, 8'h02)
    `CHK(flags_o, 3'b110)
    wait_pc(16'h0013);
    `CHK(flags_o, 3'b000)
    wait_pc(16'h0014);
    `CHK(flags_o, 3'b011)
    wait_pc(16'h0017);
    `CHK(flags_o, 3'b011)
    wait_pc(16'h0018);
    `CHK({acc_o, flags_o}, 11'h008)
    wait_pc(16'h0030);
    wait_pc(16'h0019);
    `CHK(stat_o, 8'h20)
    wait_pc(16'h001b);
    repeat (4) @(negedge clk_sys_i);
    `CHK({halted_o, pc_o}, 17'h1001b)
    // both event levels together; the core resumes after the halt
    @(posedge clk_sys_i) evt_src_i <= 2'h3;
    for (int i = 0; i < 20 && halted_o !== 1'b0; i++) @(negedge clk_sys_i);
    `CHK({halted_o, pc_o}, 17'h0001b)
    @(posedge clk_sys_i) evt_src_i <= 2'h0;
    // level 1 without its enable is recorded but never taken
    @(posedge clk_sys_i) irq_src_i <= 3'h2;
    repeat (8) @(negedge clk_sys_i);
    `CHK(stat_o, 8'hab)
    `CHK(pc_o, 16'h001b)
    // level 2 with its enable, then level 0 gated by the global enable only
    foreach (lv[k]) begin
      @(posedge clk_sys_i) irq_src_i <= lv[k];
      wait_pc(16'h0001);
      `CHK(stat_o[5], 1'b0)
      @(posedge clk_sys_i) irq_src_i <= 3'h0;
      wait_pc(16'h0006);
      `CHK(stat_o[4:2] & lv[k], lv[k])
      wait_pc(16'h001b);
      `CHK(stat_o, 8'ha0)
    end
    // store via index 0 plus offset; the no-op gives the posted store time to land
    load(8'h1b, `RCR_OP_JMP, 16'h0040);
    wait_pc(16'h0044);
    `CHK({dm_we_o, dm_addr_o, dm_wdata_o}, 25'h100155a)
    wait_pc(16'h0046);
    `CHK({dm_we_o, acc_o}, 9'h05a)
    wait_pc(16'h0047);
    `CHK(acc_o, 8'h1f)
    // second reset in mid-run: state clears at once and fetch restarts at zero
    @(posedge clk_sys_i) arst_n_i <= 1'b0;
    @(negedge clk_sys_i);
    `CHK({halted_o, pc_o, flags_o}, 20'h00001)
    `CHK({stat_o, acc_o}, {`RCR_STAT_RST, 8'h00})
    @(posedge clk_sys_i) arst_n_i <= 1'b1;
    wait_pc(16'h0010);
    summarize();
  end
endmodule // tb
bind rcr_core rcr_core_monitor #(.STACK_DEPTH(STACK_DEPTH)) u_rcr_core_monitor (
  .clk_sys_i, .arst_n_i, .instr_i, .irq_src_i, .evt_src_i, .pc_o, .acc_o, .stat_o,
  .flags_o, .halted_o);
